// ===== rtl/psw_pkg.sv
// Package for the status word and accumulator block.
// Assumes an 8-bit special-function register bus inside the core.
package psw_pkg;
    localparam int unsigned DATA_W = 8;
    // Special-function register addresses
    localparam logic [7:0] ADDR_ACC = 8'h00_E0;
    localparam logic [7:0] ADDR_PSW = 8'h00_D0;
    // Status word bit positions
    localparam int unsigned BIT_PAR = 0;
    localparam int unsigned BIT_UF1 = 1;
    localparam int unsigned BIT_OV  = 2;
    localparam int unsigned BIT_RS0 = 3;
    localparam int unsigned BIT_RS1 = 4;
    localparam int unsigned BIT_UF0 = 5;
    // Reset values
    localparam logic [7:0] ACC_RST = 8'h00_00;
    localparam logic [1:0] BANK_RST = 2'h0;
    // Bank base is bank number times bank size
    localparam int unsigned BANK_SHIFT = 3;
    typedef enum logic [1:0] {
        PSW_OP_NONE,
        PSW_OP_ARITH,
        PSW_OP_OTHER
    } psw_op_t;
endpackage

// ===== rtl/psw_core.sv
// Accumulator and program status word with parity, overflow, user flags
// and register bank select.
// Assumes the core datapath supplies results and arithmetic outcome.
// What this block does
// - Parity flag is one when accumulator has odd count of ones.
// - Bank select bits pick one of four eight-byte register banks.
// - Overflow flag set on carry, borrow, or multiply/divide overflow.
// - An arithmetic operation without excess clears the overflow flag; other operations keep it.
// - User flags change only by software writes, never by hardware.
module psw_core
    import psw_pkg::*;
(
    // Clock and reset
    input  wire logic                      sys_clk_i,
    input  wire logic                      rst_i,
    // Special-function register bus
    input  wire logic [7:0]                sfr_addr_i,
    input  wire logic                      sfr_wr_i,
    input  wire logic [psw_pkg::DATA_W-1:0] sfr_wdata_i,
    input  wire logic                      sfr_bit_wr_i,
    input  wire logic [2:0]                sfr_bit_i,
    input  wire logic                      sfr_bit_val_i,
    output logic [psw_pkg::DATA_W-1:0]     sfr_rdata_o,
    // Datapath results
    input  wire logic                      acc_load_i,
    input  wire logic [psw_pkg::DATA_W-1:0] acc_result_i,
    input  wire psw_pkg::psw_op_t          alu_op_i,
    input  wire logic                      alu_excess_i,
    // Status outputs
    output logic [psw_pkg::DATA_W-1:0]     main_accumulator_o,
    output logic                           parity_o,
    output logic                           arith_excess_flag_o,
    output logic [1:0]                     bank_select_o,
    output logic [7:0]                     bank_base_o
);
    import psw_pkg::*;

    typedef struct packed {
        logic [7:0] acc;
        logic       ov;
        logic [1:0] rs;
        logic       uf0;
        logic       uf1;
        logic       spare;
    } psw_state_t;

    psw_state_t st_q;
    psw_state_t st_d;
    logic [7:0] psw_img;
    logic       sel_acc;
    logic       sel_psw;
    logic [7:0] psw_new;
    logic [7:0] acc_new;

    assign sel_acc = (sfr_addr_i == ADDR_ACC);
    assign sel_psw = (sfr_addr_i == ADDR_PSW);

    always_comb begin
        psw_img = 8'h00_00;
        psw_img[BIT_PAR] = ^st_q.acc;
        psw_img[BIT_UF1] = st_q.uf1;
        psw_img[BIT_OV]  = st_q.ov;
        psw_img[BIT_RS0] = st_q.rs[0];
        psw_img[BIT_RS1] = st_q.rs[1];
        psw_img[BIT_UF0] = st_q.uf0;
    end

    always_comb begin
        st_d = st_q;
        psw_new = psw_img;
        acc_new = st_q.acc;
        // Datapath loads take priority over a same-cycle software write
        if (acc_load_i) begin
            st_d.acc = acc_result_i;
        end else if (sel_acc && sfr_wr_i) begin
            st_d.acc = sfr_wdata_i;
        end else if (sel_acc && sfr_bit_wr_i) begin
            acc_new[sfr_bit_i] = sfr_bit_val_i;
            st_d.acc = acc_new;
        end
        if (sel_psw && sfr_wr_i) begin
            psw_new = sfr_wdata_i;
        end else if (sel_psw && sfr_bit_wr_i) begin
            psw_new[sfr_bit_i] = sfr_bit_val_i;
        end
        // Only software paths reach these bits, except ov, which arithmetic overrides below
        st_d.uf0 = psw_new[BIT_UF0];
        st_d.uf1 = psw_new[BIT_UF1];
        st_d.rs  = {psw_new[BIT_RS1], psw_new[BIT_RS0]};
        st_d.ov  = psw_new[BIT_OV];
        // Arithmetic outcome wins over a software write of the flag
        if (alu_op_i == PSW_OP_ARITH) begin
            st_d.ov = alu_excess_i;
        end
        st_d.spare = 1'b0;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= '{acc: ACC_RST, ov: 1'b0, rs: BANK_RST,
                      uf0: 1'b0, uf1: 1'b0, spare: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    always_comb begin
        if (sel_acc) begin
            sfr_rdata_o = st_q.acc;
        end else if (sel_psw) begin
            sfr_rdata_o = psw_img;
        end else begin
            sfr_rdata_o = 8'h00_00;
        end
    end

    assign main_accumulator_o  = st_q.acc;
    // Parity is pure function of the stored accumulator: no stale cycle
    assign parity_o            = ^st_q.acc;
    assign arith_excess_flag_o = st_q.ov;
    assign bank_select_o       = st_q.rs;
    assign bank_base_o         = {3'h0, st_q.rs, 3'h0};

    // Assertions
    property p_parity;
        @(posedge sys_clk_i) disable iff (rst_i)
        parity_o == ^main_accumulator_o;
    endproperty
    a_parity: assert property (p_parity)
        else $error("parity does not match accumulator");

    property p_bank;
        @(posedge sys_clk_i) disable iff (rst_i)
        bank_base_o == ({6'h00, bank_select_o} << BANK_SHIFT);
    endproperty
    a_bank: assert property (p_bank)
        else $error("bank base wrong for selected bank");

    property p_ov_set;
        @(posedge sys_clk_i) disable iff (rst_i)
        (alu_op_i == PSW_OP_ARITH && alu_excess_i) |=> arith_excess_flag_o;
    endproperty
    a_ov_set: assert property (p_ov_set)
        else $error("overflow flag not set");

    property p_ov_clr;
        @(posedge sys_clk_i) disable iff (rst_i)
        (alu_op_i == PSW_OP_ARITH && !alu_excess_i) |=> !arith_excess_flag_o;
    endproperty
    a_ov_clr: assert property (p_ov_clr)
        else $error("overflow flag not cleared");

    property p_uf_hold;
        @(posedge sys_clk_i) disable iff (rst_i)
        !(sel_psw && (sfr_wr_i || sfr_bit_wr_i)) |=> $stable(st_q.uf1)
            && $stable(st_q.uf0);
    endproperty
    a_uf_hold: assert property (p_uf_hold)
        else $error("user flag changed without software write");

    property p_par_sw;
        @(posedge sys_clk_i) disable iff (rst_i)
        (sel_acc && sfr_wr_i && !acc_load_i)
            |=> parity_o == ^$past(sfr_wdata_i);
    endproperty
    a_par_sw: assert property (p_par_sw)
        else $error("parity lags software accumulator write");

    property p_par_alu;
        @(posedge sys_clk_i) disable iff (rst_i)
        acc_load_i |=> (main_accumulator_o == $past(acc_result_i))
            ##0 (parity_o == ^$past(acc_result_i));
    endproperty
    a_par_alu: assert property (p_par_alu)
        else $error("parity lags datapath accumulator load");

    property p_rs_wr;
        @(posedge sys_clk_i) disable iff (rst_i)
        (sel_psw && sfr_wr_i && alu_op_i != PSW_OP_ARITH)
            |=> bank_select_o == $past(sfr_wdata_i[BIT_RS1:BIT_RS0]);
    endproperty
    a_rs_wr: assert property (p_rs_wr)
        else $error("bank select not written");

    // Bank select must not drift while software leaves the status word alone
    property p_rs_hold;
        @(posedge sys_clk_i) disable iff (rst_i)
        !(sel_psw && (sfr_wr_i || sfr_bit_wr_i)) |=> $stable(bank_select_o);
    endproperty
    a_rs_hold: assert property (p_rs_hold)
        else $error("bank select changed without software write");

    // Arithmetic outcome overrides a software write of the same cycle
    property p_ov_sw;
        @(posedge sys_clk_i) disable iff (rst_i)
        (sel_psw && sfr_wr_i && alu_op_i == PSW_OP_ARITH)
            |=> arith_excess_flag_o == $past(alu_excess_i);
    endproperty
    a_ov_sw: assert property (p_ov_sw)
        else $error("software write beat arithmetic outcome");

    property p_rd_psw;
        @(posedge sys_clk_i) disable iff (rst_i)
        sel_psw |-> (sfr_rdata_o[BIT_PAR] == parity_o)
            && (sfr_rdata_o[BIT_OV] == arith_excess_flag_o);
    endproperty
    a_rd_psw: assert property (p_rd_psw)
        else $error("status word readback wrong");

    property p_acc_bit;
        @(posedge sys_clk_i) disable iff (rst_i)
        (sel_acc && sfr_bit_wr_i && !sfr_wr_i && !acc_load_i)
            |=> main_accumulator_o[$past(sfr_bit_i)] == $past(sfr_bit_val_i);
    endproperty
    a_acc_bit: assert property (p_acc_bit)
        else $error("accumulator bit write lost");

    c_bank3: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        bank_select_o == 2'h3);
    c_ov: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        $rose(arith_excess_flag_o));
    c_par: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        $rose(parity_o));
    c_acc_bit: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        sel_acc && sfr_bit_wr_i);
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the accumulator and status word block.
// Assumes psw_pkg is compiled first; the bench drives every port itself.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import psw_pkg::*;
    logic       sys_clk_i = 0, rst_i = 1, sfr_wr_i = 0, sfr_bit_wr_i = 0;
    logic       sfr_bit_val_i = 0, acc_load_i = 0, alu_excess_i = 0;
    logic [7:0] sfr_addr_i = 0, sfr_wdata_i = 0, acc_result_i = 0;
    logic [2:0] sfr_bit_i = 0;
    psw_op_t    alu_op_i = PSW_OP_NONE;
    logic [7:0] sfr_rdata_o, main_accumulator_o, bank_base_o;
    logic [1:0] bank_select_o;
    logic       parity_o, arith_excess_flag_o;
    int         bad_count = 0, check_count = 0;
    psw_core psw_core_inst (.sys_clk_i, .rst_i, .sfr_addr_i, .sfr_wr_i,
        .sfr_wdata_i, .sfr_bit_wr_i, .sfr_bit_i, .sfr_bit_val_i,
        .sfr_rdata_o, .acc_load_i, .acc_result_i, .alu_op_i,
        .alu_excess_i, .main_accumulator_o, .parity_o,
        .arith_excess_flag_o, .bank_select_o, .bank_base_o);
    initial begin
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(string n, logic e, logic g);
        chk8(n, {7'h0, e}, {7'h0, g});
    endtask
    // Strobes rise at one edge, are taken at the next, outputs read after
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge sys_clk_i);
        sfr_addr_i <= a;
        sfr_wdata_i <= d;
        sfr_wr_i <= 1;
        @(posedge sys_clk_i);
        sfr_wr_i <= 0;
        #1;
    endtask
    task automatic bw(logic [7:0] a, int unsigned b, logic v);
        @(posedge sys_clk_i);
        sfr_addr_i <= a;
        sfr_bit_i <= 3'(b);
        sfr_bit_val_i <= v;
        sfr_bit_wr_i <= 1;
        @(posedge sys_clk_i);
        sfr_bit_wr_i <= 0;
        #1;
    endtask
    task automatic alu(psw_op_t o, logic x, logic l, logic [7:0] r);
        @(posedge sys_clk_i);
        alu_op_i <= o;
        alu_excess_i <= x;
        acc_load_i <= l;
        acc_result_i <= r;
        @(posedge sys_clk_i);
        alu_op_i <= PSW_OP_NONE;
        acc_load_i <= 0;
        #1;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge sys_clk_i);
        sfr_addr_i <= a;
        #1;
    endtask
    task automatic t_parity();
        logic [7:0] v[4] = '{8'h07, 8'h03, 8'h80, 8'hFF};
        foreach (v[i]) begin
            wr(ADDR_ACC, v[i]);
            chk8("acc", v[i], main_accumulator_o);
            chk1("parity", ^v[i], parity_o);
        end
        rd(ADDR_ACC);
        chk8("acc read", 8'hFF, sfr_rdata_o);
        bw(ADDR_ACC, 0, 0);
        chk8("acc bit", 8'hFE, main_accumulator_o);
        chk1("parity bit", 1'b1, parity_o);
        alu(PSW_OP_OTHER, 0, 1, 8'h01);
        chk1("parity load", 1'b1, parity_o);
    endtask
    task automatic t_bank();
        for (int b = 0; b < 4; b++) begin
            wr(ADDR_PSW, 8'(b << BANK_SHIFT));
            chk8("bank", 8'(b), {6'h0, bank_select_o});
            chk8("base", 8'(b * 8), bank_base_o);
        end
        bw(ADDR_PSW, BIT_RS0, 0);
        chk8("base bit", 8'h10, bank_base_o);
    endtask
    task automatic t_excess();
        alu(PSW_OP_ARITH, 1, 0, 8'h00);
        chk1("ov set", 1'b1, arith_excess_flag_o);
        alu(PSW_OP_OTHER, 0, 1, 8'h22);
        chk1("ov other", 1'b1, arith_excess_flag_o);
        alu(PSW_OP_ARITH, 0, 1, 8'h33);
        chk1("ov clear", 1'b0, arith_excess_flag_o);
        // Software sets the flag while an arithmetic result clears it
        fork
            wr(ADDR_PSW, 8'h04);
            alu(PSW_OP_ARITH, 0, 0, 8'h00);
        join
        chk1("ov beats sw", 1'b0, arith_excess_flag_o);
    endtask
    task automatic t_user();
        bw(ADDR_PSW, BIT_UF1, 1);
        alu(PSW_OP_ARITH, 1, 1, 8'h5A);
        wr(ADDR_ACC, 8'hC3);
        rd(ADDR_PSW);
        chk1("uf1 kept", 1'b1, sfr_rdata_o[BIT_UF1]);
        chk1("ov read", 1'b1, sfr_rdata_o[BIT_OV]);
        chk1("par read", 1'b0, sfr_rdata_o[BIT_PAR]);
        bw(ADDR_PSW, BIT_UF1, 0);
        rd(ADDR_PSW);
        chk1("uf1 clear", 1'b0, sfr_rdata_o[BIT_UF1]);
        rd(8'h55);
        chk8("unmapped", 8'h00, sfr_rdata_o);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        // Far beyond the roughly sixty cycles the scenarios need
        #40000;
        bad_count++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge sys_clk_i);
        rst_i <= 0;
        #1;
        chk8("acc rst", ACC_RST, main_accumulator_o);
        chk8("base rst", 8'h00, bank_base_o);
        chk1("ov rst", 1'b0, arith_excess_flag_o);
        t_parity();
        t_bank();
        t_excess();
        t_user();
        end_of_test();
    end
endmodule
